// ### rtl/dmct_consts.vh
// Constants for the dual mode compare timer: register offsets,
// field positions, reset values and prescaler ratios.
// Assumes a byte-wide peripheral bus with an 8-bit register address.
`ifndef DMCT_CONSTS_VH
`define DMCT_CONSTS_VH

// Register byte offsets
`define DMCT_OFS_CTRL        8'h00
`define DMCT_OFS_STAT        8'h01
`define DMCT_OFS_CNT_HI      8'h02
`define DMCT_OFS_CNT_LO      8'h03
`define DMCT_OFS_CMP_HI      8'h04
`define DMCT_OFS_CMP_LO      8'h05
`define DMCT_OFS_CLK_GATE    8'h06
`define DMCT_OFS_EDGE_SEL    8'h07

// Reset values
`define DMCT_RST_CNT         16'h0000
`define DMCT_RST_CMP         16'hFFFF
`define DMCT_RST_CTRL        8'h00
`define DMCT_RST_STAT        8'h00
`define DMCT_RST_CLK_GATE    8'hFF
`define DMCT_RST_EDGE_SEL    8'h00

// Control register fields
`define DMCT_CTRL_LVL_HI     7
`define DMCT_CTRL_CKS_HI_MSB 6
`define DMCT_CTRL_CKS_HI_LSB 4
`define DMCT_CTRL_MODE8      6
`define DMCT_CTRL_LVL_LO     3
`define DMCT_CTRL_CKS_LO_MSB 2
`define DMCT_CTRL_CKS_LO_LSB 0

// Control/status register fields
`define DMCT_ST_WRAP_HI      7
`define DMCT_ST_MATCH_HI     6
`define DMCT_ST_WIE_HI       5
`define DMCT_ST_CLR_HI       4
`define DMCT_ST_WRAP_LO      3
`define DMCT_ST_MATCH_LO     2
`define DMCT_ST_WIE_LO       1
`define DMCT_ST_CLR_LO       0

// Other single bits
`define DMCT_GATE_SLEEP_BIT  2
`define DMCT_EDGE_SEL_BIT    3

// Clock select codes
`define DMCT_CKS_DIV32       3'h4
`define DMCT_CKS_DIV16       3'h5
`define DMCT_CKS_DIV4        3'h6
`define DMCT_CKS_SUB4        3'h7

// Prescaler ratios
`define DMCT_DIV_32          32
`define DMCT_DIV_16          16
`define DMCT_DIV_4           4
`define DMCT_SUB_DIV         4

`endif

// ### rtl/dmct_event_sync.v
// Two-stage synchroniser and selectable edge detector for event_input.
// Assumes the event pulse is held for at least two system clocks.
`timescale 1ns/100ps
module dmct_event_sync (
  input  wire ref_clk_i,
  input  wire rstn_i,
  input  wire event_input_i,
  input  wire rise_sel_i,
  output wire edge_pulse_o
);
  reg meta_reg;
  reg sync_reg;
  reg prev_reg;

  // Only sync_reg reads meta_reg, keeping metastability contained
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= event_input_i; // R23
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edge picked by the edge select bit
  assign edge_pulse_o = rise_sel_i ? (sync_reg & ~prev_reg)
                                   : (~sync_reg & prev_reg); // R17 R23
endmodule // dmct_event_sync

// ### rtl/dmct_timer.v
// Dual mode compare timer: 16-bit counter with compare, or two 8-bit
// halves, reached over a byte-wide peripheral bus with a byte latch.
// Assumes single-cycle read/write strobes, synchronous to ref_clk_i.
`timescale 1ns/100ps
`include "dmct_consts.vh"

// What this block does
// R01: Low half clears on match when enabled
// R02: Gate bit 2 zero stops the timer
// R03: Byte latch mediates sixteen-bit transfers
// R04: CPU accesses upper byte first
// R05: Eight-bit mode accepts bytes any order
// R06: Upper write latches; lower write loads both
// R07: Counter upper read latches lower byte
// R08: Compare reads bypass the byte latch
// R09: Mode bit selects sixteen or two eight
// R10: Reset values for counter, compare, controls
// R11: Full match sets high match flag, irq
// R12: Full counter clears on match when enabled
// R13: Full wrap sets high wrap flag, irq
// R14: Eight-bit halves match independently
// R15: Eight-bit halves wrap independently
// R16: Clock select picks four internal sources
// R17: Low select zero counts event edges
// R18: Event pulses last two clocks minimum
// R19: Toggle outputs preset by level, invert
// R20: Flags cleared by zero after read
// R21: Match fires when counter leaves value
// R22: Per-half irq combines CPU enable
// R23: Event input synchronised before edge detect
module dmct_timer #(
  parameter SUB_DIV = `DMCT_SUB_DIV
) (
  input  wire       ref_clk_i,
  input  wire       rstn_i,
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  input  wire       sub_clk_tick_i,
  input  wire       event_input_i,
  input  wire       cpu_irq_en_high_i,
  input  wire       cpu_irq_en_low_i,
  output reg  [7:0] rdata_o,
  output reg        toggle_out_high_o,
  output reg        toggle_out_low_o,
  output reg        irq_high_o,
  output reg        irq_low_o
);
  reg  [15:0] cnt_reg;
  reg  [15:0] cmp_reg;
  reg  [7:0]  ctrl_reg;
  reg  [7:0]  stat_reg;
  reg  [7:0]  gate_reg;
  reg  [7:0]  edge_reg;
  reg  [7:0]  byte_latch_reg;
  reg  [4:0]  pre_reg;
  reg  [4:0]  pre_prev_reg;
  reg  [3:0]  sub_reg;
  reg  [3:0]  sub_prev_reg;
  reg  [7:0]  flag_seen_reg;
  reg         eq_hi_reg;
  reg         eq_lo_reg;
  reg         eq_full_reg;
  reg  [15:0] cnt_next;
  reg  [7:0]  stat_next;
  reg         tick_hi;
  reg         tick_lo;
  wire        run;
  wire        mode8;
  wire        ev_pulse;
  wire [2:0]  cks_hi;
  wire [2:0]  cks_lo;
  wire        tick_32;
  wire        tick_16;
  wire        tick_4;
  wire        tick_w4;
  wire        match_hi;
  wire        match_lo;
  wire        match_full;
  wire        wrap_hi;
  wire        wrap_lo;
  wire        wrap_full;
  wire        wr_cnt_lo;
  wire        wr_cnt_hi;

  assign run    = gate_reg[`DMCT_GATE_SLEEP_BIT]; // R02
  assign mode8  = ctrl_reg[`DMCT_CTRL_MODE8]; // R09
  assign cks_hi = ctrl_reg[`DMCT_CTRL_CKS_HI_MSB:`DMCT_CTRL_CKS_HI_LSB];
  assign cks_lo = ctrl_reg[`DMCT_CTRL_CKS_LO_MSB:`DMCT_CTRL_CKS_LO_LSB];

  dmct_event_sync u_event_sync (
    .ref_clk_i     (ref_clk_i),
    .rstn_i        (rstn_i),
    .event_input_i (event_input_i),
    .rise_sel_i    (edge_reg[`DMCT_EDGE_SEL_BIT]),
    .edge_pulse_o  (ev_pulse)
  );

  // Free-running prescalers; one tick when the divided bit falls
  // Gating freezes the phase as well, so after a restart the first
  // tick may come early: interval counts are exact to one tick only
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      pre_reg      <= 5'h00;
      pre_prev_reg <= 5'h00;
      sub_reg      <= 4'h0;
      sub_prev_reg <= 4'h0;
    end else if (run) begin
      pre_reg      <= pre_reg + 5'h01;
      pre_prev_reg <= pre_reg;
      if (sub_clk_tick_i)
        sub_reg <= (sub_reg == SUB_DIV - 1) ? 4'h0 : sub_reg + 4'h1;
      sub_prev_reg <= sub_reg;
    end
  end
  assign tick_32 = pre_prev_reg[4] & ~pre_reg[4];
  assign tick_16 = pre_prev_reg[3] & ~pre_reg[3];
  assign tick_4  = pre_prev_reg[1] & ~pre_reg[1];
  // Subclock ticks are assumed already synchronous to ref_clk_i
  assign tick_w4 = (sub_prev_reg != 4'h0) & (sub_reg == 4'h0);

  // Count source select per half
  // Codes 0 to 3 all select the event pin; bit 2 alone decides
  always @* begin
    case (cks_lo)
      `DMCT_CKS_DIV32: tick_lo = tick_32; // R16
      `DMCT_CKS_DIV16: tick_lo = tick_16;
      `DMCT_CKS_DIV4:  tick_lo = tick_4;
      `DMCT_CKS_SUB4:  tick_lo = tick_w4;
      default:         tick_lo = ev_pulse & ~cks_lo[2]; // R17
    endcase
    case (cks_hi)
      `DMCT_CKS_DIV32: tick_hi = tick_32;
      `DMCT_CKS_DIV16: tick_hi = tick_16;
      `DMCT_CKS_DIV4:  tick_hi = tick_4;
      `DMCT_CKS_SUB4:  tick_hi = tick_w4;
      default:         tick_hi = ev_pulse & ~cks_hi[2];
    endcase
    tick_lo = tick_lo & run;
    tick_hi = tick_hi & run;
  end

  // Match fires on the tick that moves the counter off the value
  // Match wins over wrap on one tick, so a clear never also flags wrap
  assign match_lo   = tick_lo & eq_lo_reg; // R21
  assign match_hi   = tick_hi & eq_hi_reg;
  assign match_full = tick_lo & eq_full_reg;
  assign wrap_lo    = tick_lo & (cnt_reg[7:0] == 8'hFF) & ~match_lo;
  assign wrap_hi    = tick_hi & (cnt_reg[15:8] == 8'hFF) & ~match_hi;
  assign wrap_full  = tick_lo & (cnt_reg == 16'hFFFF) & ~match_full;

  assign wr_cnt_lo = wr_i & (addr_i == `DMCT_OFS_CNT_LO);
  assign wr_cnt_hi = wr_i & (addr_i == `DMCT_OFS_CNT_HI);

  // Next counter value; a CPU write overrides counting
  // In sixteen-bit mode the low select clocks the whole counter
  always @* begin
    cnt_next = cnt_reg;
    if (!mode8) begin
      if (match_full && stat_reg[`DMCT_ST_CLR_HI])
        cnt_next = 16'h0000; // R12
      else if (tick_lo)
        cnt_next = cnt_reg + 16'h0001;
      if (wr_cnt_lo)
        cnt_next = {byte_latch_reg, wdata_i}; // R06
    end else begin
      if (match_lo && stat_reg[`DMCT_ST_CLR_LO])
        cnt_next[7:0] = 8'h00; // R01 R14
      else if (tick_lo)
        cnt_next[7:0] = cnt_reg[7:0] + 8'h01;
      if (match_hi && stat_reg[`DMCT_ST_CLR_HI])
        cnt_next[15:8] = 8'h00; // R14
      else if (tick_hi)
        cnt_next[15:8] = cnt_reg[15:8] + 8'h01;
      if (wr_cnt_lo)
        cnt_next[7:0] = wdata_i; // R05
      if (wr_cnt_hi)
        cnt_next[15:8] = wdata_i;
    end
  end

  // Status next: hardware set wins over software clear
  always @* begin
    stat_next = stat_reg;
    if (wr_i && addr_i == `DMCT_OFS_STAT) begin
      stat_next[`DMCT_ST_WIE_HI] = wdata_i[`DMCT_ST_WIE_HI];
      stat_next[`DMCT_ST_CLR_HI] = wdata_i[`DMCT_ST_CLR_HI];
      stat_next[`DMCT_ST_WIE_LO] = wdata_i[`DMCT_ST_WIE_LO];
      stat_next[`DMCT_ST_CLR_LO] = wdata_i[`DMCT_ST_CLR_LO];
      // Flag clears only after it was read as one; ones ignored
      stat_next[7:6] = stat_reg[7:6]
                       & ~(~wdata_i[7:6] & flag_seen_reg[7:6]); // R20
      stat_next[3:2] = stat_reg[3:2]
                       & ~(~wdata_i[3:2] & flag_seen_reg[3:2]);
    end
    if (mode8 ? match_hi : match_full)
      stat_next[`DMCT_ST_MATCH_HI] = 1'b1; // R11 R14
    if (mode8 ? wrap_hi : wrap_full)
      stat_next[`DMCT_ST_WRAP_HI] = 1'b1; // R13 R15
    if (match_lo)
      stat_next[`DMCT_ST_MATCH_LO] = 1'b1; // R14
    if (wrap_lo)
      stat_next[`DMCT_ST_WRAP_LO] = 1'b1; // R15
  end

  // Registers and bus writes
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cnt_reg        <= `DMCT_RST_CNT; // R10
      cmp_reg        <= `DMCT_RST_CMP;
      ctrl_reg       <= `DMCT_RST_CTRL;
      stat_reg       <= `DMCT_RST_STAT;
      gate_reg       <= `DMCT_RST_CLK_GATE; // R02
      edge_reg       <= `DMCT_RST_EDGE_SEL;
      byte_latch_reg <= 8'h00;
      flag_seen_reg  <= 8'h00;
      eq_hi_reg      <= 1'b0;
      eq_lo_reg      <= 1'b0;
      eq_full_reg    <= 1'b0;
    end else begin
      cnt_reg     <= cnt_next;
      stat_reg    <= stat_next;
      // Equality is registered so a match needs the following tick
      eq_lo_reg   <= (cnt_next[7:0] == cmp_reg[7:0]);
      eq_hi_reg   <= (cnt_next[15:8] == cmp_reg[15:8]);
      eq_full_reg <= (cnt_next == cmp_reg); // R11
      // A read mark lasts until the flag is written zero, so a flag set
      // again later must be read once more before it can be cleared
      if (rd_i && addr_i == `DMCT_OFS_STAT)
        flag_seen_reg <= stat_reg;
      else if (wr_i && addr_i == `DMCT_OFS_STAT)
        flag_seen_reg <= flag_seen_reg & wdata_i; // R20
      if (wr_i) begin
        case (addr_i)
          `DMCT_OFS_CTRL:     ctrl_reg <= wdata_i;
          `DMCT_OFS_CLK_GATE: gate_reg <= wdata_i;
          `DMCT_OFS_EDGE_SEL: edge_reg <= wdata_i;
          `DMCT_OFS_CNT_HI:   if (!mode8) byte_latch_reg <= wdata_i; // R06
          `DMCT_OFS_CMP_HI: begin
            if (mode8)
              cmp_reg[15:8] <= wdata_i; // R05
            else
              byte_latch_reg <= wdata_i; // R03 R04
          end
          `DMCT_OFS_CMP_LO: begin
            if (mode8)
              cmp_reg[7:0] <= wdata_i;
            else
              cmp_reg <= {byte_latch_reg, wdata_i}; // R06
          end
          default: ;
        endcase
      end
      if (rd_i && addr_i == `DMCT_OFS_CNT_HI && !mode8)
        byte_latch_reg <= cnt_reg[7:0]; // R07
    end
  end

  // Read data and toggle outputs, all registered
  // Counter low reads the latch in sixteen-bit mode, not the live count
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rdata_o           <= 8'h00;
      toggle_out_high_o <= 1'b0;
      toggle_out_low_o  <= 1'b0;
      irq_high_o        <= 1'b0;
      irq_low_o         <= 1'b0;
    end else begin
      if (rd_i) begin
        case (addr_i)
          `DMCT_OFS_CTRL:     rdata_o <= ctrl_reg;
          `DMCT_OFS_STAT:     rdata_o <= stat_reg;
          `DMCT_OFS_CNT_HI:   rdata_o <= cnt_reg[15:8];
          `DMCT_OFS_CNT_LO:
            rdata_o <= mode8 ? cnt_reg[7:0] : byte_latch_reg; // R07
          `DMCT_OFS_CMP_HI:   rdata_o <= cmp_reg[15:8]; // R08
          `DMCT_OFS_CMP_LO:   rdata_o <= cmp_reg[7:0];
          `DMCT_OFS_CLK_GATE: rdata_o <= gate_reg;
          `DMCT_OFS_EDGE_SEL: rdata_o <= edge_reg;
          default:            rdata_o <= 8'h00;
        endcase
      end
      // A control write presets the level and wins over a toggle
      if (wr_i && addr_i == `DMCT_OFS_CTRL) begin
        toggle_out_high_o <= wdata_i[`DMCT_CTRL_LVL_HI]; // R19
        toggle_out_low_o  <= wdata_i[`DMCT_CTRL_LVL_LO];
      end else begin
        if (mode8 ? match_hi : match_full)
          toggle_out_high_o <= ~toggle_out_high_o; // R19
        if (match_lo)
          toggle_out_low_o <= ~toggle_out_low_o;
      end
      // Level request per half, gated by the CPU enables
      irq_high_o <= cpu_irq_en_high_i & (stat_next[`DMCT_ST_MATCH_HI]
                    | (stat_next[`DMCT_ST_WRAP_HI]
                       & stat_next[`DMCT_ST_WIE_HI])); // R22 R11 R13
      irq_low_o  <= cpu_irq_en_low_i & mode8
                    & (stat_next[`DMCT_ST_MATCH_LO]
                    | (stat_next[`DMCT_ST_WRAP_LO]
                       & stat_next[`DMCT_ST_WIE_LO])); // R22 R15
    end
  end
endmodule // dmct_timer

// ### bench/dmct_timer_asserts.sv
// Port-level checker for the dual mode compare timer.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module dmct_timer_asserts #(
  parameter SUB_DIV = 4
) (
  input wire       ref_clk_i,
  input wire       rstn_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire       cpu_irq_en_high_i,
  input wire       cpu_irq_en_low_i,
  input wire [7:0] rdata_o,
  input wire       toggle_out_high_o,
  input wire       toggle_out_low_o,
  input wire       irq_high_o,
  input wire       irq_low_o
);
  // Single domain, so clock and reset are stated once
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  // Outputs leave reset low
  AST_RST_OUT: assert property ($rose(rstn_i) |->
    rdata_o == 8'h00 && !irq_high_o && !irq_low_o
    && !toggle_out_high_o && !toggle_out_low_o)
    else $error("output not low after reset");
  // Read data only moves on a read
  AST_RD_HOLD: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved without a read");
  // Requests need the controller enable
  AST_IRQ_HI: assert property (!cpu_irq_en_high_i |=> !irq_high_o)
    else $error("high request while disabled");
  AST_IRQ_LO: assert property (!cpu_irq_en_low_i |=> !irq_low_o)
    else $error("low request while disabled");
  // Preset level shows right after the control write
  AST_TOG_HI: assert property (wr_i && addr_i == 8'h00 |=>
    toggle_out_high_o == $past(wdata_i[7]))
    else $error("high toggle ignored preset");
  AST_TOG_LO: assert property (wr_i && addr_i == 8'h00 |=>
    toggle_out_low_o == $past(wdata_i[3]))
    else $error("low toggle ignored preset");
  // Write then read back returns the written byte
  AST_GATE_RW: assert property (wr_i && addr_i == 8'h06 ##1 !wr_i
    ##1 rd_i && addr_i == 8'h06 |=> rdata_o == $past(wdata_i, 3))
    else $error("gate register lost its value");
  AST_CMP_LO: assert property (wr_i && addr_i == 8'h05 ##1 !wr_i
    ##1 rd_i && addr_i == 8'h05 |=> rdata_o == $past(wdata_i, 3))
    else $error("compare low read back wrong");
endmodule // dmct_timer_asserts

bind dmct_timer dmct_timer_asserts #(.SUB_DIV(SUB_DIV)) u_chk (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .cpu_irq_en_high_i(cpu_irq_en_high_i),
  .cpu_irq_en_low_i(cpu_irq_en_low_i), .rdata_o(rdata_o),
  .toggle_out_high_o(toggle_out_high_o),
  .toggle_out_low_o(toggle_out_low_o),
  .irq_high_o(irq_high_o), .irq_low_o(irq_low_o)
);

// ### bench/dmct_event_src.sv
// External event source for the timer's event pin.
// Assumes pulse is called from one process only.
`timescale 1ns/100ps
module dmct_event_src (
  input  wire ref_clk_i,
  output reg  event_o
);
  initial event_o = 1'b0;

  // Three clocks high, safely above the two-clock minimum
  task pulse;
    begin
      @(posedge ref_clk_i);
      event_o <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      event_o <= 1'b0;
      repeat (6) @(posedge ref_clk_i); // Edge lands after the sync
      @(negedge ref_clk_i); // Return where outputs are settled
    end
  endtask
endmodule // dmct_event_src

// ### bench/test_dual_mode_compare_timer.sv
// Self-checking bench for the dual mode compare timer.
// Assumes the design, checker and event source are compiled first.
`timescale 1ns/100ps
module test_dual_mode_compare_timer;
  localparam [71:0] RV = 72'h00_00_FF_FF_FF_00_00_00_00;
  reg        clk = 1'b0;
  reg        rstn = 1'b0;
  reg  [7:0] addr = 8'h00;
  reg  [7:0] wdata = 8'h00;
  reg        wr = 1'b0;
  reg        rd = 1'b0;
  reg        en_hi = 1'b0;
  reg        en_lo = 1'b0;
  reg        sub_tick = 1'b0;
  reg  [7:0] d;
  wire       ev;
  wire [7:0] rdata;
  wire       tog_hi;
  wire       tog_lo;
  wire       irq_hi;
  wire       irq_lo;
  integer    failures = 0;
  integer    check_count = 0;
  integer    cycles = 0;
  integer    i;

  // Subclock ticks come from the bench, one per clock that sub_tick is held high
  dmct_timer #(.SUB_DIV(4)) u_dut (.ref_clk_i(clk), .rstn_i(rstn),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .sub_clk_tick_i(sub_tick), .event_input_i(ev),
    .cpu_irq_en_high_i(en_hi), .cpu_irq_en_low_i(en_lo),
    .rdata_o(rdata), .toggle_out_high_o(tog_hi),
    .toggle_out_low_o(tog_lo), .irq_high_o(irq_hi), .irq_low_o(irq_lo));
  dmct_event_src u_ev (.ref_clk_i(clk), .event_o(ev));

  always #5 clk = ~clk;

  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      give_verdict;
    end
  end

  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // Strobes rise and fall on rising edges only
  task wr_b(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask

  // Data is registered, so sample it half a cycle later
  task rd_b(input [7:0] a, output [7:0] v);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdata;
    end
  endtask

  task rc(input string nm, input [7:0] a, input [7:0] e);
    reg [7:0] v;
    begin
      rd_b(a, v);
      chk(nm, v, e);
    end
  endtask

  task give_verdict;
    begin
      $display("Checks %0d, failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // Scenarios in order; later ones rely on earlier state
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 9; i = i + 1)
      rc("reset", i[7:0], RV[8*i+:8]);
    wr_b(8'h06, 8'hA5);
    rc("gate", 8'h06, 8'hA5);
    wr_b(8'h06, 8'hFF);
    wr_b(8'h01, 8'hFF);
    rc("status", 8'h01, 8'h33);
    wr_b(8'h04, 8'h12);
    rc("cmp_hi", 8'h04, 8'hFF);
    wr_b(8'h05, 8'h34);
    rc("cmp_lo", 8'h05, 8'h34);
    rc("cmp_hi", 8'h04, 8'h12);
    wr_b(8'h02, 8'h01);
    wr_b(8'h03, 8'hFE);
    wr_b(8'h04, 8'h01);
    wr_b(8'h05, 8'hFF);
    wr_b(8'h01, 8'h10);
    en_hi <= 1'b1;
    rc("cnt_hi", 8'h02, 8'h01);
    u_ev.pulse;
    rc("cnt_lo", 8'h03, 8'hFE);
    chk("irq_hi", irq_hi, 1'b0);
    u_ev.pulse;
    chk("tog_hi", tog_hi, 1'b1);
    chk("irq_hi", irq_hi, 1'b1);
    // Low byte matched on the same tick, so its flag is set as well
    rc("status", 8'h01, 8'h54);
    rc("cnt_hi", 8'h02, 8'h00);
    wr_b(8'h01, 8'h30);
    repeat (2) @(negedge clk);
    chk("irq_hi", irq_hi, 1'b0);
    wr_b(8'h02, 8'hFF);
    wr_b(8'h03, 8'hFF);
    u_ev.pulse;
    rc("status", 8'h01, 8'hB4);
    chk("irq_hi", irq_hi, 1'b1);
    @(posedge clk) en_hi <= 1'b0;
    repeat (2) @(negedge clk);
    chk("irq_hi", irq_hi, 1'b0);
    // Split mode: high half counts the subclock divided by four
    wr_b(8'h00, 8'h70);
    wr_b(8'h01, 8'h03);
    wr_b(8'h03, 8'hFF);
    wr_b(8'h02, 8'h7E);
    rc("cnt_hi", 8'h02, 8'h7E);
    for (i = 0; i < 8; i = i + 1)
      @(posedge clk) sub_tick <= 1'b1;
    @(posedge clk) sub_tick <= 1'b0;
    rc("sub_div", 8'h02, 8'h80);
    wr_b(8'h05, 8'h01);
    @(posedge clk) en_lo <= 1'b1;
    u_ev.pulse;
    rc("status", 8'h01, 8'h0B);
    u_ev.pulse;
    u_ev.pulse;
    chk("tog_lo", tog_lo, 1'b1);
    chk("irq_lo", irq_lo, 1'b1);
    rc("status", 8'h01, 8'h0F);
    rc("cnt_lo", 8'h03, 8'h00);
    // Rising edge selected: one pulse must count exactly once
    wr_b(8'h07, 8'h08);
    u_ev.pulse;
    rc("event_rise", 8'h03, 8'h01);
    // Eight periods of each divisor; free prescaler phase allows 7..9
    for (i = 0; i < 3; i = i + 1) begin
      wr_b(8'h00, 8'h04 + i[7:0]);
      wr_b(8'h02, 8'h00);
      wr_b(8'h03, 8'h00);
      repeat (256 >> (i == 2 ? 3 : i)) @(posedge clk);
      rd_b(8'h02, d);
      chk("prescale_hi", d, 8'h00);
      rd_b(8'h03, d);
      chk("prescale", d >= 8'h07 && d <= 8'h09, 1'b1);
    end
    wr_b(8'h06, 8'hFB);
    wr_b(8'h02, 8'h00);
    wr_b(8'h03, 8'h00);
    repeat (40) @(posedge clk);
    rc("cnt_hi", 8'h02, 8'h00);
    rc("cnt_lo", 8'h03, 8'h00);
    give_verdict;
  end
endmodule // test_dual_mode_compare_timer
